// ### verilog/temp_remap_pkg.sv
// Package with register map, field layout and carriers for the temperature remap block.
package temp_remap_pkg;
  localparam logic [7:0] OFS_R1_VALUE   = 8'h25;
  localparam logic [7:0] OFS_LOCAL      = 8'h26;
  localparam logic [7:0] OFS_C0_VALUE   = 8'h33;
  localparam logic [7:0] OFS_C0_LOW     = 8'h34;
  localparam logic [7:0] OFS_C0_HIGH    = 8'h35;
  localparam logic [7:0] OFS_CPU_CFG    = 8'h36;
  localparam logic [7:0] OFS_C0_START   = 8'h3B;
  localparam logic [7:0] OFS_C0_SPAN    = 8'h3C;
  localparam logic [7:0] OFS_C0_OTC     = 8'h3D;
  localparam logic [7:0] OFS_R1_LOW     = 8'h4E;
  localparam logic [7:0] OFS_R1_HIGH    = 8'h4F;
  localparam logic [7:0] OFS_PWM1       = 8'h5C;
  localparam logic [7:0] OFS_PWM2       = 8'h5D;
  localparam logic [7:0] OFS_PWM3       = 8'h5E;
  localparam logic [7:0] OFS_R1_SPAN    = 8'h5F;
  localparam logic [7:0] OFS_R1_ACOU    = 8'h62;
  localparam logic [7:0] OFS_R1_START   = 8'h67;
  localparam logic [7:0] OFS_R1_OTC     = 8'h6A;
  localparam logic [7:0] OFS_HYST_A     = 8'h6D;
  localparam logic [7:0] OFS_HYST_B     = 8'h6E;
  localparam logic [7:0] OFS_R1_OFFSET  = 8'h70;
  localparam logic [7:0] OFS_EXT_FRAC   = 8'h77;
  localparam logic [7:0] OFS_FMT_CFG    = 8'h7D;
  localparam logic [7:0] OFS_C0_DYN     = 8'h8A;
  localparam logic [7:0] OFS_R1_DYN     = 8'h8B;
  localparam logic [7:0] OFS_C0_OFFSET  = 8'h94;
  localparam int         SUBST_BIT      = 4;
  localparam int         FMT_BIT        = 0;
  localparam int         BEHAV_LSB      = 5;
  localparam logic [2:0] BEHAV_DEFAULT  = 3'h0;
  localparam logic [9:0] FAULT_TWOS     = 10'h200;
  localparam logic [9:0] FAULT_OFS64    = 10'h000;
  localparam logic [7:0] OFS64_BIAS     = 8'h40;
  localparam int         AVG_COUNT      = 16;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // Bias sequence of one remote measurement.
  typedef enum logic [3:0] {
    BIAS_IDLE = 4'h1,
    BIAS_N1   = 4'h2,
    BIAS_N2   = 4'h4,
    BIAS_DONE = 4'h8
  } bias_e;
  // One raw conversion from the converter.
  typedef struct packed {
    logic       local_ok;
    logic [9:0] local_code;
    logic       diff_ok;
    logic [9:0] diff_one;
    logic [9:0] diff_two;
    logic       cpu_ok;
    logic [7:0] cpu_code;
  } sample_s;
  // Register bus request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_s;
endpackage : temp_remap_pkg

// ### verilog/temp_remap.sv
// Temperature result storage, coding and substitution remap with register port.
`timescale 1ns/1ps
module temp_remap #(
  parameter int AVG_N = temp_remap_pkg::AVG_COUNT
) (
  // Clock and reset.
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  // Register port.
  input  wire temp_remap_pkg::bus_req_s bus_req,
  output logic [7:0]                    rdata,
  // Converter results and bias control.
  input  wire logic                     sample_valid,
  input  wire temp_remap_pkg::sample_s  sample,
  output logic [1:0]                    bias_sel,
  // Zone, hysteresis and local fault outputs to the fan logic.
  output logic [2:0]                    pwm_cpu_zone,
  output logic [3:0]                    hyst_remote_two,
  output logic [3:0]                    hyst_local,
  output logic                          fault_local
);
  // Complete block state.
  typedef struct packed {
    logic [7:0]  rdata;
    logic [7:0]  cfg;
    logic [7:0]  fmt;
    logic [7:0]  r1_low, r1_high, r1_start, r1_otc, r1_span, r1_acou, r1_off, r1_dyn;
    logic [7:0]  c0_low, c0_high, c0_start, c0_span, c0_otc, c0_off, c0_dyn;
    logic [7:0]  hyst_a, hyst_b;
    logic [7:0]  pwm1, pwm2, pwm3;
    logic [9:0]  local_t, remote_t;
    logic [7:0]  cpu_t;
    logic [13:0] acc;
    logic [4:0]  avg_cnt;
    logic        frozen;
    logic [2:0]  unread;
    temp_remap_pkg::bias_e bias;
    logic [1:0]  bias_sel;
    logic [2:0]  zone;
    logic [3:0]  hyst_r2, hyst_loc;
    logic        fault;
  } state_s;

  state_s st_reg, st_next;
  logic       subst;
  logic [7:0] loc_fmt, rem_fmt;
  logic [9:0] delta_sum;
  // The average divides by shifting, so AVG_N must be a power of two.
  localparam int AVG_SHIFT = $clog2(AVG_N);

  assign subst = st_reg.cfg[temp_remap_pkg::SUBST_BIT];

  // Apply the selected coding to a ten-bit twos complement reading.
  function automatic logic [7:0] code_byte(input logic [9:0] t, input logic ofs64);
    logic [7:0] hi;
    hi = t[9:2];
    if (ofs64)
      code_byte = (t == temp_remap_pkg::FAULT_TWOS) ? temp_remap_pkg::FAULT_OFS64[9:2]
                                                   : hi + temp_remap_pkg::OFS64_BIAS;
    else
      code_byte = hi;
  endfunction : code_byte

  assign loc_fmt = code_byte(st_reg.local_t, st_reg.fmt[temp_remap_pkg::FMT_BIT]);
  assign rem_fmt = code_byte(st_reg.remote_t, st_reg.fmt[temp_remap_pkg::FMT_BIT]);
  assign delta_sum = 10'((11'(sample.diff_one) + 11'(sample.diff_two)) >> 1);

  // Next-state logic: bus, capture, averaging and bias sequence.
  always_comb begin
    logic [7:0] a;
    logic [7:0] d;
    logic       sw;
    a  = bus_req.addr;
    d  = bus_req.wdata;
    sw = subst;
    st_next = st_reg;
    st_next.rdata = 8'h00;
    if (bus_req.rd) begin
      case (a)
        temp_remap_pkg::OFS_R1_VALUE:  st_next.rdata = sw ? st_reg.cpu_t : rem_fmt;
        temp_remap_pkg::OFS_C0_VALUE:  st_next.rdata = sw ? rem_fmt : st_reg.cpu_t;
        temp_remap_pkg::OFS_LOCAL:     st_next.rdata = loc_fmt;
        temp_remap_pkg::OFS_EXT_FRAC:
          st_next.rdata = {2'h0, st_reg.remote_t[1:0], st_reg.local_t[1:0], 2'h0};
        temp_remap_pkg::OFS_CPU_CFG:   st_next.rdata = st_reg.cfg;
        temp_remap_pkg::OFS_FMT_CFG:   st_next.rdata = st_reg.fmt;
        temp_remap_pkg::OFS_R1_LOW:    st_next.rdata = sw ? st_reg.c0_low : st_reg.r1_low;
        temp_remap_pkg::OFS_C0_LOW:    st_next.rdata = sw ? st_reg.r1_low : st_reg.c0_low;
        temp_remap_pkg::OFS_R1_HIGH:   st_next.rdata = sw ? st_reg.c0_high : st_reg.r1_high;
        temp_remap_pkg::OFS_C0_HIGH:   st_next.rdata = sw ? st_reg.r1_high : st_reg.c0_high;
        temp_remap_pkg::OFS_R1_START:  st_next.rdata = sw ? st_reg.c0_start : st_reg.r1_start;
        temp_remap_pkg::OFS_C0_START:  st_next.rdata = sw ? st_reg.r1_start : st_reg.c0_start;
        temp_remap_pkg::OFS_R1_OTC:    st_next.rdata = sw ? st_reg.c0_otc : st_reg.r1_otc;
        temp_remap_pkg::OFS_C0_OTC:    st_next.rdata = sw ? st_reg.r1_otc : st_reg.c0_otc;
        temp_remap_pkg::OFS_R1_OFFSET: st_next.rdata = sw ? st_reg.c0_off : st_reg.r1_off;
        temp_remap_pkg::OFS_C0_OFFSET: st_next.rdata = sw ? st_reg.r1_off : st_reg.c0_off;
        temp_remap_pkg::OFS_R1_DYN:    st_next.rdata = sw ? st_reg.c0_dyn : st_reg.r1_dyn;
        temp_remap_pkg::OFS_C0_DYN:    st_next.rdata = sw ? st_reg.r1_dyn : st_reg.c0_dyn;
        temp_remap_pkg::OFS_R1_SPAN:
          st_next.rdata = {sw ? st_reg.c0_span[7:4] : st_reg.r1_span[7:4], st_reg.r1_span[3:0]};
        temp_remap_pkg::OFS_R1_ACOU:
          st_next.rdata = {st_reg.r1_acou[7:4], sw ? st_reg.c0_span[3:0] : st_reg.r1_acou[3:0]};
        temp_remap_pkg::OFS_C0_SPAN:
          st_next.rdata = sw ? {st_reg.r1_span[7:4], st_reg.r1_acou[3:0]}
                             : st_reg.c0_span;
        temp_remap_pkg::OFS_HYST_A:
          st_next.rdata = sw ? {st_reg.hyst_b[3:0], st_reg.hyst_b[7:4]} : st_reg.hyst_a;
        temp_remap_pkg::OFS_HYST_B:
          st_next.rdata = sw ? {st_reg.hyst_a[3:0], st_reg.hyst_a[7:4]} : st_reg.hyst_b;
        temp_remap_pkg::OFS_PWM1:      st_next.rdata = st_reg.pwm1;
        temp_remap_pkg::OFS_PWM2:      st_next.rdata = st_reg.pwm2;
        temp_remap_pkg::OFS_PWM3:      st_next.rdata = st_reg.pwm3;
        default:                       st_next.rdata = 8'h00;
      endcase
      if (a == temp_remap_pkg::OFS_EXT_FRAC) begin
        st_next.frozen = 1'b1;
        st_next.unread = 3'h7;
      end else if (st_reg.frozen) begin
        if (a == temp_remap_pkg::OFS_LOCAL) st_next.unread[0] = 1'b0;
        if (a == temp_remap_pkg::OFS_R1_VALUE) st_next.unread[1] = 1'b0;
        if (a == temp_remap_pkg::OFS_C0_VALUE) st_next.unread[2] = 1'b0;
        if ((st_next.unread & 3'h7) == 3'h0) st_next.frozen = 1'b0;
      end
    end
    if (bus_req.wr) begin
      case (a)
        temp_remap_pkg::OFS_CPU_CFG:   st_next.cfg = d;
        temp_remap_pkg::OFS_FMT_CFG:   st_next.fmt = d;
        temp_remap_pkg::OFS_R1_LOW:    if (sw) st_next.c0_low = d; else st_next.r1_low = d;
        temp_remap_pkg::OFS_C0_LOW:    if (sw) st_next.r1_low = d; else st_next.c0_low = d;
        temp_remap_pkg::OFS_R1_HIGH:   if (sw) st_next.c0_high = d; else st_next.r1_high = d;
        temp_remap_pkg::OFS_C0_HIGH:   if (sw) st_next.r1_high = d; else st_next.c0_high = d;
        temp_remap_pkg::OFS_R1_START:  if (sw) st_next.c0_start = d; else st_next.r1_start = d;
        temp_remap_pkg::OFS_C0_START:  if (sw) st_next.r1_start = d; else st_next.c0_start = d;
        temp_remap_pkg::OFS_R1_OTC:    if (sw) st_next.c0_otc = d; else st_next.r1_otc = d;
        temp_remap_pkg::OFS_C0_OTC:    if (sw) st_next.r1_otc = d; else st_next.c0_otc = d;
        temp_remap_pkg::OFS_R1_OFFSET: if (sw) st_next.c0_off = d; else st_next.r1_off = d;
        temp_remap_pkg::OFS_C0_OFFSET: if (sw) st_next.r1_off = d; else st_next.c0_off = d;
        temp_remap_pkg::OFS_R1_DYN:    if (sw) st_next.c0_dyn = d; else st_next.r1_dyn = d;
        temp_remap_pkg::OFS_C0_DYN:    if (sw) st_next.r1_dyn = d; else st_next.c0_dyn = d;
        temp_remap_pkg::OFS_R1_SPAN: begin
          st_next.r1_span[3:0] = d[3:0];
          if (sw) st_next.c0_span[7:4] = d[7:4]; else st_next.r1_span[7:4] = d[7:4];
        end
        temp_remap_pkg::OFS_R1_ACOU: begin
          st_next.r1_acou[7:4] = d[7:4];
          if (sw) st_next.c0_span[3:0] = d[3:0]; else st_next.r1_acou[3:0] = d[3:0];
        end
        temp_remap_pkg::OFS_C0_SPAN: begin
          if (sw) begin
            st_next.r1_span[7:4] = d[7:4];
            st_next.r1_acou[3:0] = d[3:0];
          end else begin
            st_next.c0_span = d;
          end
        end
        temp_remap_pkg::OFS_HYST_A:
          if (sw) st_next.hyst_b = {d[3:0], d[7:4]}; else st_next.hyst_a = d;
        temp_remap_pkg::OFS_HYST_B:
          if (sw) st_next.hyst_a = {d[3:0], d[7:4]}; else st_next.hyst_b = d;
        temp_remap_pkg::OFS_PWM1:      st_next.pwm1 = d;
        temp_remap_pkg::OFS_PWM2:      st_next.pwm2 = d;
        temp_remap_pkg::OFS_PWM3:      st_next.pwm3 = d;
        default: ;
      endcase
    end
    // bias sequence; each conversion steps the bias once more.
    case (st_reg.bias)
      temp_remap_pkg::BIAS_IDLE: begin
        st_next.bias = temp_remap_pkg::BIAS_N1;
        st_next.bias_sel = 2'h1;
      end
      temp_remap_pkg::BIAS_N1:
        if (sample_valid) begin
          st_next.bias = temp_remap_pkg::BIAS_N2;
          st_next.bias_sel = 2'h2;
        end
      temp_remap_pkg::BIAS_N2:
        if (sample_valid) begin
          st_next.bias = temp_remap_pkg::BIAS_DONE;
          st_next.bias_sel = 2'h0;
        end
      temp_remap_pkg::BIAS_DONE: st_next.bias = temp_remap_pkg::BIAS_IDLE;
      default: st_next.bias = temp_remap_pkg::BIAS_IDLE;
    endcase
    // average sixteen remote cycles; stored twos complement
    if (sample_valid && sample.diff_ok && st_reg.bias == temp_remap_pkg::BIAS_N2) begin
      if (st_reg.avg_cnt == 5'(AVG_N - 1)) begin
        if (!st_next.frozen)
          st_next.remote_t = 10'((st_reg.acc + 14'(delta_sum)) >> AVG_SHIFT);
        st_next.acc = 14'h0;
        st_next.avg_cnt = 5'h0;
      end else begin
        st_next.acc = st_reg.acc + 14'(delta_sum);
        st_next.avg_cnt = st_reg.avg_cnt + 5'h1;
      end
    end
    // capture held while frozen; local and CPU capture
    if (sample_valid && !st_next.frozen) begin
      if (sample.local_ok) st_next.local_t = sample.local_code;
      if (sample.cpu_ok) st_next.cpu_t = sample.cpu_code;
    end
    // behaviour-default outputs follow the CPU zone only while substitution is on
    st_next.zone = {st_reg.pwm3[7:5] == temp_remap_pkg::BEHAV_DEFAULT,
                    st_reg.pwm2[7:5] == temp_remap_pkg::BEHAV_DEFAULT,
                    st_reg.pwm1[7:5] == temp_remap_pkg::BEHAV_DEFAULT} & {3{sw}};
    st_next.fault = (st_reg.local_t == temp_remap_pkg::FAULT_TWOS);
    // hysteresis exchange, registered so the outputs come from flops.
    st_next.hyst_r2  = sw ? st_reg.hyst_b[3:0] : st_reg.hyst_b[7:4];
    st_next.hyst_loc = sw ? st_reg.hyst_b[7:4] : st_reg.hyst_b[3:0];
  end

  // State register.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.bias <= temp_remap_pkg::BIAS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops.
  assign rdata           = st_reg.rdata;
  assign bias_sel        = st_reg.bias_sel;
  assign pwm_cpu_zone    = st_reg.zone;
  assign hyst_remote_two = st_reg.hyst_r2;
  assign hyst_local      = st_reg.hyst_loc;
  assign fault_local     = st_reg.fault;

  // Checks on what the block drives; bus inputs trigger the register port checks, and in a_cfg_subst and a_subst_low also give the expected value.

  a_cfg_subst: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.wr && bus_req.addr == temp_remap_pkg::OFS_CPU_CFG
      |=> subst == $past(bus_req.wdata[temp_remap_pkg::SUBST_BIT]))
    else $error("substitution flag wrong");

  a_subst_value: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_R1_VALUE && subst
      |=> rdata == $past(st_reg.cpu_t))
    else $error("remote one value not swapped");

  a_c0_value_abs: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_C0_VALUE && subst
      && !st_reg.fmt[temp_remap_pkg::FMT_BIT]
      |=> rdata == $past(st_reg.remote_t[9:2]))
    else $error("CPU zero value not swapped");

  a_local_read: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_LOCAL
      && !st_reg.fmt[temp_remap_pkg::FMT_BIT]
      |=> rdata == $past(st_reg.local_t[9:2]))
    else $error("local value wrong");

  a_subst_low: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.wr && bus_req.addr == temp_remap_pkg::OFS_R1_LOW && subst
      |=> st_reg.c0_low == $past(bus_req.wdata))
    else $error("low limit write not swapped");

  a_read_idle: assert property (@(posedge clock) disable iff (!arst_n)
    !bus_req.rd |=> rdata == 8'h00)
    else $error("read data without read");

  a_span_swap: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_C0_SPAN && subst
      |=> rdata == {$past(st_reg.r1_span[7:4]), $past(st_reg.r1_acou[3:0])})
    else $error("span register not swapped");

  a_hyst_read: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_HYST_A && subst
      |=> rdata == {$past(st_reg.hyst_b[3:0]), $past(st_reg.hyst_b[7:4])})
    else $error("hysteresis nibbles not swapped");

  a_hyst_swap: assert property (@(posedge clock) disable iff (!arst_n)
    subst |=> hyst_remote_two == $past(st_reg.hyst_b[3:0])
      && hyst_local == $past(st_reg.hyst_b[7:4]))
    else $error("hysteresis outputs not swapped");

  a_zone_move: assert property (@(posedge clock) disable iff (!arst_n)
    !subst |=> pwm_cpu_zone == 3'h0)
    else $error("zone moved outside substitution");

  a_zone_pwm1: assert property (@(posedge clock) disable iff (!arst_n)
    subst |=> pwm_cpu_zone[0]
      == ($past(st_reg.pwm1[7:5]) == temp_remap_pkg::BEHAV_DEFAULT))
    else $error("PWM one zone wrong");

  a_fault_flag: assert property (@(posedge clock) disable iff (!arst_n)
    st_reg.local_t == temp_remap_pkg::FAULT_TWOS |=> fault_local)
    else $error("local fault not flagged");

  a_ofs64_local: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_LOCAL
      && st_reg.fmt[temp_remap_pkg::FMT_BIT]
      && st_reg.local_t != temp_remap_pkg::FAULT_TWOS
      |=> rdata == 8'($past(st_reg.local_t[9:2]) + temp_remap_pkg::OFS64_BIAS))
    else $error("offset coding wrong");

  a_ofs64_fault: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_LOCAL
      && st_reg.fmt[temp_remap_pkg::FMT_BIT]
      && st_reg.local_t == temp_remap_pkg::FAULT_TWOS |=> rdata == 8'h00)
    else $error("offset fault code wrong");

  a_frac_layout: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_EXT_FRAC
      |=> rdata == {2'h0, $past(st_reg.remote_t[1:0]), $past(st_reg.local_t[1:0]), 2'h0})
    else $error("fraction layout wrong");

  a_avg_range: assert property (@(posedge clock) disable iff (!arst_n)
    st_reg.avg_cnt < 5'(AVG_N))
    else $error("average counter overran");

  a_bias_order: assert property (@(posedge clock) disable iff (!arst_n)
    st_reg.bias == temp_remap_pkg::BIAS_N1 && sample_valid |=> bias_sel == 2'h2)
    else $error("bias order wrong");

  a_bias_done: assert property (@(posedge clock) disable iff (!arst_n)
    st_reg.bias == temp_remap_pkg::BIAS_N2 && sample_valid |=> bias_sel == 2'h0)
    else $error("bias not back to base");

  a_freeze_arm: assert property (@(posedge clock) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == temp_remap_pkg::OFS_EXT_FRAC |=> st_reg.frozen)
    else $error("fraction read did not freeze");

  a_freeze_hold: assert property (@(posedge clock) disable iff (!arst_n)
    st_reg.frozen && st_next.frozen |=> $stable(st_reg.local_t)
      && $stable(st_reg.remote_t) && $stable(st_reg.cpu_t))
    else $error("reading changed while frozen");

  // Main scenarios reached.
  c_subst_read: cover property (@(posedge clock) subst && bus_req.rd);
  c_freeze:     cover property (@(posedge clock) st_reg.frozen);
  c_avg_done:   cover property (@(posedge clock) st_reg.avg_cnt == 5'(AVG_N - 1));
  c_fault:      cover property (@(posedge clock) fault_local);
  c_zone_move:  cover property (@(posedge clock) pwm_cpu_zone != 3'h0);
endmodule : temp_remap

// ### dv/converter_model.sv
// Converter model that hands one conversion result to the block on request.
`timescale 1ns/1ps
module converter_model (
  // Clock and reset.
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  // Request from the bench.
  input  wire logic                    go,
  input  wire temp_remap_pkg::sample_s next_sample,
  // Result toward the block.
  output logic                         sample_valid,
  output temp_remap_pkg::sample_s      sample
);
  // A result stands one cycle; between results the lines toggle so a stale value is never trusted.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sample_valid <= 1'b0;
      sample       <= '0;
    end else begin
      sample_valid <= go;
      sample       <= go ? next_sample : ~sample;
    end
  end
endmodule : converter_model

// ### dv/temp_remap_tb.sv
// Self-checking bench for the temperature remap block.
`timescale 1ns/1ps
module temp_remap_tb;
  logic                     clock;
  logic                     arst_n;
  temp_remap_pkg::bus_req_s bus_req;
  logic [7:0]               rdata;
  logic                     go;
  temp_remap_pkg::sample_s  nxt;
  logic                     sample_valid;
  temp_remap_pkg::sample_s  sample;
  logic [1:0]               bias_sel;
  logic [2:0]               pwm_cpu_zone;
  logic [3:0]               hyst_remote_two;
  logic [3:0]               hyst_local;
  logic                     fault_local;
  logic                     seen1;
  logic                     seen12;
  logic [7:0]               h0;
  int                       fail_count;
  int                       num_checks;
  logic [7:0] pa [6] = '{8'h4E, 8'h4F, 8'h67, 8'h6A, 8'h70, 8'h8B};
  logic [7:0] pb [6] = '{8'h34, 8'h35, 8'h3B, 8'h3D, 8'h94, 8'h8A};

  // Averaging depth lowered to two so remote results appear quickly.
  temp_remap #(.AVG_N(2)) uut (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
    .rdata(rdata), .sample_valid(sample_valid), .sample(sample), .bias_sel(bias_sel),
    .pwm_cpu_zone(pwm_cpu_zone), .hyst_remote_two(hyst_remote_two),
    .hyst_local(hyst_local), .fault_local(fault_local));

  converter_model conv_m (.clock(clock), .arst_n(arst_n), .go(go), .next_sample(nxt),
    .sample_valid(sample_valid), .sample(sample));

  // Free-running clock at 250 MHz.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Bias steps are recorded so their order can be judged at the end.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seen1  <= 1'b0;
      seen12 <= 1'b0;
    end else begin
      if (bias_sel == 2'd1) seen1 <= 1'b1;
      if (bias_sel == 2'd2 && seen1) seen12 <= 1'b1;
    end
  end

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk8($sformatf("reg %h", a), exp, d);
  endtask : chk_rd

  task automatic conv(input logic [9:0] lc, input logic dok, input logic [9:0] dc,
                      input logic cok, input logic [7:0] cc);
    @(posedge clock);
    go  <= 1'b1;
    nxt <= {1'b1, lc, dok, dc, dc, cok, cc};
    @(posedge clock);
    go  <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : conv

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Watchdog sized well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  initial begin
    logic [7:0] d;
    arst_n = 1'b0;
    bus_req = '0;
    go = 1'b0;
    nxt = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    chk_rd(temp_remap_pkg::OFS_R1_LOW, temp_remap_pkg::RESET_BYTE);
    chk_rd(8'hFF, 8'h00);
    // Remote averaging: a result takes two bias sequences of two samples each.
    repeat (3) conv(10'h0C9, 1'b1, 10'h0CB, 1'b0, 8'h00);
    chk_rd(temp_remap_pkg::OFS_R1_VALUE, 8'h00);
    conv(10'h0C9, 1'b1, 10'h0CB, 1'b0, 8'h00);
    rd(temp_remap_pkg::OFS_EXT_FRAC, d);
    chk8("remote fraction", 8'h30, d & 8'h30);
    chk8("local fraction", 8'h04, d & 8'h0C);
    chk_rd(temp_remap_pkg::OFS_R1_VALUE, 8'h32);
    chk_rd(temp_remap_pkg::OFS_LOCAL, 8'h32);
    chk_rd(temp_remap_pkg::OFS_C0_VALUE, 8'h00);
    // A reading started with the fraction register stays frozen until all parts are read.
    rd(temp_remap_pkg::OFS_EXT_FRAC, d);
    conv(10'h200, 1'b0, 10'h000, 1'b0, 8'h00);
    chk_rd(temp_remap_pkg::OFS_LOCAL, 8'h32);
    rd(temp_remap_pkg::OFS_R1_VALUE, d);
    rd(temp_remap_pkg::OFS_C0_VALUE, d);
    conv(10'h200, 1'b0, 10'h000, 1'b0, 8'h00);
    chk_rd(temp_remap_pkg::OFS_LOCAL, 8'h80);
    chk8("fault flag", 8'h01, {7'h00, fault_local});
    wr(temp_remap_pkg::OFS_FMT_CFG, 8'h01);
    conv(10'h0C9, 1'b0, 10'h000, 1'b0, 8'h00);
    chk_rd(temp_remap_pkg::OFS_LOCAL, 8'h72);
    wr(temp_remap_pkg::OFS_FMT_CFG, 8'h00);
    // Fill both sides of every swapped pair with distinct values.
    for (int i = 0; i < 6; i++) begin
      wr(pa[i], 8'h10 + 8'(i));
      wr(pb[i], 8'h20 + 8'(i));
      chk_rd(pa[i], 8'h10 + 8'(i));
    end
    wr(temp_remap_pkg::OFS_R1_SPAN, 8'hA5);
    wr(temp_remap_pkg::OFS_R1_ACOU, 8'h96);
    wr(temp_remap_pkg::OFS_C0_SPAN, 8'h7E);
    wr(temp_remap_pkg::OFS_HYST_A, 8'h12);
    wr(temp_remap_pkg::OFS_HYST_B, 8'h34);
    wr(temp_remap_pkg::OFS_PWM1, 8'h00);
    wr(temp_remap_pkg::OFS_PWM2, 8'h20);
    wr(temp_remap_pkg::OFS_PWM3, 8'h1F);
    #1 h0 = {hyst_remote_two, hyst_local};
    chk8("hyst normal", 8'h34, h0);
    // Host enters substitution mode and then uses the swapped formats.
    wr(temp_remap_pkg::OFS_CPU_CFG, 8'h10);
    conv(10'h0C9, 1'b0, 10'h000, 1'b1, 8'hF6);
    chk_rd(temp_remap_pkg::OFS_R1_VALUE, 8'hF6);
    for (int i = 0; i < 6; i++) begin
      chk_rd(pa[i], 8'h20 + 8'(i));
      chk_rd(pb[i], 8'h10 + 8'(i));
    end
    chk_rd(temp_remap_pkg::OFS_R1_SPAN, 8'h75);
    chk_rd(temp_remap_pkg::OFS_C0_SPAN, 8'hA6);
    chk_rd(temp_remap_pkg::OFS_R1_ACOU, 8'h9E);
    chk_rd(temp_remap_pkg::OFS_HYST_A, 8'h43);
    chk_rd(temp_remap_pkg::OFS_HYST_B, 8'h21);
    chk8("hyst swap", 8'h43, {hyst_remote_two, hyst_local});
    chk8("pwm zone", 8'h05, {5'h00, pwm_cpu_zone});
    wr(temp_remap_pkg::OFS_CPU_CFG, 8'h00);
    chk_rd(pa[0], 8'h10);
    chk8("bias order", 8'h01, {7'h00, seen12});
    summarize();
  end
endmodule : temp_remap_tb
